/* hw/inc_top.sv */
module inc_top
  import inc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire inc_instr_t instr,
  input wire logic [NSRC-1:0] src_req,
  input wire logic nmi_req,
  input wire logic watch_overflow_test,
  input wire logic [7:0] port4_in,
  output inc_save_t save,
  output logic standby_release
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] pick_first(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : pick_first

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return a == OFF_REQ || a == OFF_MASK || a == OFF_PRIO ||
           a == OFF_PSW || a == OFF_REQ1 || a == OFF_MASK1 ||
           a == OFF_KRC || a == OFF_EDGE0 || a == OFF_EDGE1 ||
           a == OFF_STAT;
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_have_r, w_have_r, aw_have_nxt, w_have_nxt;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane0_r;
  logic aw_hs, w_hs, wr_do, ar_hs;
  logic reg_we;
  logic [7:0] rd_byte;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign wr_do = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign aw_have_nxt = (aw_have_r | aw_hs) & ~wr_do;
  assign w_have_nxt = (w_have_r | w_hs) & ~wr_do;
  assign reg_we = wr_do & w_lane0_r & is_mapped(aw_addr_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r <= 8'h00;
      w_lane0_r <= 1'b0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      s_axi_awready <= ~aw_have_nxt;
      s_axi_wready <= ~w_have_nxt;
      if (aw_hs)
      begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_byte_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_rvalid <= ~s_axi_rready;
      s_axi_arready <= s_axi_rready;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] req_r, mask_r, prio_r, psw_r, req1_r, mask1_r, krc_r;
  logic [7:0] edge0_r, edge1_r, p4_prev_r, ack_clr, set1;
  logic [2:0] sp_r;
  inc_kind_t kind_stk [STK_DEPTH];
  inc_kind_t cur_kind, new_kind;
  inc_seq_t seq_r;
  logic nmi_pend_r, key_fall;

  always_comb
  begin
    rd_byte = 8'h00;
    case (s_axi_araddr)
      OFF_REQ: rd_byte = req_r;
      OFF_MASK: rd_byte = mask_r;
      OFF_PRIO: rd_byte = prio_r;
      OFF_PSW: rd_byte = psw_r;
      OFF_REQ1: rd_byte = req1_r;
      OFF_MASK1: rd_byte = mask1_r;
      OFF_KRC: rd_byte = krc_r;
      OFF_EDGE0: rd_byte = edge0_r;
      OFF_EDGE1: rd_byte = edge1_r;
      OFF_STAT: rd_byte = {3'h0, sp_r, cur_kind};
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic defer_cls, take_trap, may_ack, nmi_go, mask_go, any_ack;
  logic allow_hi, allow_lo, sel_v, sel_prio;
  logic [7:0] elig, hi_req, lo_req;
  logic [3:0] pick_hi, pick_lo;
  logic [2:0] sel_idx;
  logic [1:0] sp_top;

  assign sp_top = sp_r[1:0] - 2'h1;
  assign cur_kind = (sp_r == 3'h0) ? KIND_NONE : kind_stk[sp_top];
  // Enable and in-service level come from the status word.
  assign defer_cls = instr.trap_ret | instr.irq_ret | instr.unmask_all |
                     instr.mask_all | instr.psw_wr | instr.psw_touch |
                     instr.irq_reg_touch;
  assign take_trap = seq_r == SQ_IDLE && instr.done && instr.trap;
  // The trap instruction itself is no boundary for other sources.
  assign may_ack = seq_r == SQ_IDLE && instr.done && !instr.trap &&
                   !defer_cls;
  assign elig = req_r & ~mask_r & {8{psw_r[PSW_IE_BIT]}};
  assign hi_req = elig & ~prio_r;
  assign lo_req = elig & prio_r;
  assign allow_hi = cur_kind != KIND_NMI &&
                    !(cur_kind == KIND_MASK && !psw_r[PSW_ISP_BIT]);
  assign allow_lo = cur_kind == KIND_NONE || cur_kind == KIND_TRAP;
  assign pick_hi = pick_first(hi_req & {8{allow_hi}});
  assign pick_lo = pick_first(lo_req & {8{allow_lo}});
  assign sel_v = pick_hi[3] | pick_lo[3];
  assign sel_idx = pick_hi[3] ? pick_hi[2:0] : pick_lo[2:0];
  assign sel_prio = ~pick_hi[3];
  assign nmi_go = may_ack && nmi_pend_r && cur_kind != KIND_NMI;
  assign mask_go = may_ack && !nmi_go && sel_v;
  assign any_ack = take_trap | nmi_go | mask_go;
  assign new_kind = take_trap ? KIND_TRAP : (nmi_go ? KIND_NMI : KIND_MASK);

  always_comb
  begin
    ack_clr = 8'h00;
    ack_clr[sel_idx] = mask_go;
  end

  // Source pulses set flags regardless of the group bit; a set wins
  // over a clear by software or by acknowledge in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_r <= RST_REQ;
    end
    else
    begin
      req_r <= (((reg_we && aw_addr_r == OFF_REQ) ? w_byte_r : req_r)
                & ~ack_clr) | src_req;
    end
  end

  // Several non-maskable requests while one is held collapse into one.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_pend_r <= 1'b0;
    end
    else
    begin
      nmi_pend_r <= nmi_req | (nmi_pend_r & ~nmi_go);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_r <= RST_MASK;
      prio_r <= RST_PRIO;
      mask1_r <= RST_MASK1;
      krc_r <= RST_KRC;
      edge0_r <= RST_EDGE;
      edge1_r <= RST_EDGE;
    end
    else if (reg_we)
    begin
      case (aw_addr_r)
        OFF_MASK: mask_r <= w_byte_r;
        OFF_PRIO: prio_r <= w_byte_r;
        OFF_MASK1: mask1_r <= w_byte_r;
        OFF_KRC: krc_r <= w_byte_r;
        OFF_EDGE0: edge0_r <= w_byte_r;
        OFF_EDGE1: edge1_r <= w_byte_r;
        default: mask_r <= mask_r;
      endcase
    end
  end

  // Later assignments take precedence: acknowledge overrides all others on the enable bit, and a non-trap one also on the in-service bit.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      psw_r <= RST_PSW;
    end
    else
    begin
      if (reg_we && aw_addr_r == OFF_PSW)
      begin
        psw_r <= w_byte_r;
      end
      if (seq_r == SQ_IDLE && instr.done &&
          (instr.psw_wr | instr.trap_ret | instr.irq_ret))
      begin
        psw_r <= instr.psw_val;
      end
      if (seq_r == SQ_IDLE && instr.done && instr.unmask_all)
      begin
        psw_r[PSW_IE_BIT] <= 1'b1;
      end
      if (seq_r == SQ_IDLE && instr.done && instr.mask_all)
      begin
        psw_r[PSW_IE_BIT] <= 1'b0;
      end
      if (any_ack)
      begin
        psw_r[PSW_IE_BIT] <= 1'b0;
      end
      if (nmi_go)
      begin
        psw_r[PSW_ISP_BIT] <= 1'b0;
      end
      if (mask_go)
      begin
        psw_r[PSW_ISP_BIT] <= sel_prio;
      end
    end
  end

  // Only the kind of each open service is kept; nesting deeper than
  // the stack saturates and the deepest levels are then not tracked.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sp_r <= 3'h0;
    end
    else if (any_ack && sp_r != STK_FULL)
    begin
      kind_stk[sp_r[1:0]] <= new_kind;
      sp_r <= sp_r + 3'h1;
    end
    else if (seq_r == SQ_IDLE && instr.done && sp_r != 3'h0 &&
             (instr.trap_ret | instr.irq_ret))
    begin
      sp_r <= sp_r - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Save and vector sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_r <= SQ_IDLE;
      save <= '0;
    end
    else
    begin
      case (seq_r)
        SQ_IDLE:
        begin
          if (any_ack)
          begin
            seq_r <= SQ_PSW;
            save.save_psw <= 1'b1;
            save.program_state_word <= psw_r;
            save.vec <= take_trap ? VEC_TRAP : (nmi_go ? VEC_NMI :
                        VEC_MASK_BASE + {12'h000, sel_idx, 1'b0});
          end
        end
        SQ_PSW:
        begin
          seq_r <= SQ_PC;
          save.save_psw <= 1'b0;
          save.save_pc <= 1'b1;
        end
        SQ_PC:
        begin
          seq_r <= SQ_VEC;
          save.save_pc <= 1'b0;
          save.load_vec <= 1'b1;
        end
        SQ_VEC:
        begin
          seq_r <= SQ_IDLE;
          save.load_vec <= 1'b0;
        end
        default: seq_r <= SQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Test inputs
  // ----------------------------------------------------------------
  assign key_fall = |(p4_prev_r & ~port4_in);

  always_comb
  begin
    set1 = 8'h00;
    set1[WT_FLAG_BIT] = watch_overflow_test;
    set1[KR_FLAG_BIT] = key_fall;
  end

  // No hardware clear: flags drop only on a software write of zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req1_r <= RST_REQ1;
      p4_prev_r <= RST_PORT4;
    end
    else
    begin
      p4_prev_r <= port4_in;
      req1_r <= ((reg_we && aw_addr_r == OFF_REQ1) ? w_byte_r : req1_r)
                | set1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      standby_release <= 1'b0;
    end
    else
    begin
      standby_release <= (req1_r[WT_FLAG_BIT] & ~mask1_r[WT_MASK_BIT]) |
                         (req1_r[KR_FLAG_BIT] & ~krc_r[KR_MASK_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TRAP_VEC: assert property (
    take_trap |=> ##2 (save.load_vec && save.vec == VEC_TRAP))
    else $error("trap did not load its vector");
  AST_SAVE_ORDER: assert property (
    save.save_psw |=> save.save_pc ##1 save.load_vec)
    else $error("save order broken");
  AST_TRAP_IE: assert property (
    take_trap |=> !psw_r[PSW_IE_BIT] && save.program_state_word == $past(psw_r))
    else $error("trap kept enable or lost status word");
  AST_NMI_NEST: assert property (
    cur_kind == KIND_NMI |-> !mask_go && !nmi_go)
    else $error("nesting under non-maskable");
  AST_HI_HOLD: assert property (
    cur_kind == KIND_MASK && !psw_r[PSW_ISP_BIT] |-> !mask_go)
    else $error("maskable nested under high service");
  AST_LOW_NEST: assert property (
    mask_go && cur_kind == KIND_MASK |-> !sel_prio)
    else $error("low group nested in maskable service");
  AST_IE_BLOCK: assert property (
    mask_go |-> psw_r[PSW_IE_BIT] && req_r[sel_idx] && !mask_r[sel_idx])
    else $error("ineligible maskable acknowledged");
  AST_DEFER: assert property (
    instr.done && defer_cls |-> !nmi_go && !mask_go)
    else $error("acknowledge after deferring instruction");
  AST_ISP_COPY: assert property (
    mask_go |=> psw_r[PSW_ISP_BIT] == $past(sel_prio) &&
                !psw_r[PSW_IE_BIT])
    else $error("in-service flag not copied");
  AST_KEY_SET: assert property (
    key_fall |=> req1_r[KR_FLAG_BIT])
    else $error("key edge flag not set");
  AST_STBY: assert property (
    req1_r[KR_FLAG_BIT] && !krc_r[KR_MASK_BIT] |=> standby_release)
    else $error("standby release missing");

  COV_TRAP: cover property (take_trap ##3 save.load_vec);
  COV_NMI_IN_TRAP: cover property (nmi_go && cur_kind == KIND_TRAP);
  COV_HI_NEST: cover property (mask_go && cur_kind == KIND_MASK);
  COV_KEY: cover property (key_fall ##1 standby_release);

endmodule : inc_top

/* hw/inc_pkg.sv */
package inc_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam int NSRC = 8;
  localparam logic [7:0] OFF_REQ = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_PRIO = 8'h08;
  localparam logic [7:0] OFF_PSW = 8'h0C;
  localparam logic [7:0] OFF_REQ1 = 8'h10;
  localparam logic [7:0] OFF_MASK1 = 8'h14;
  localparam logic [7:0] OFF_KRC = 8'h18;
  localparam logic [7:0] OFF_EDGE0 = 8'h1C;
  localparam logic [7:0] OFF_EDGE1 = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  localparam logic [7:0] RST_REQ = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_PRIO = 8'hFF;
  localparam logic [7:0] RST_PSW = 8'h02;
  localparam logic [7:0] RST_REQ1 = 8'h00;
  localparam logic [7:0] RST_MASK1 = 8'hFF;
  localparam logic [7:0] RST_KRC = 8'h02;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_PORT4 = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_BIT = 1;
  localparam int WT_FLAG_BIT = 0;
  localparam int KR_FLAG_BIT = 7;
  localparam int WT_MASK_BIT = 0;
  localparam int KR_MASK_BIT = 1;

  // ----------------------------------------------------------------
  // Vectors, bus answers, nesting depth
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_TRAP = 16'h003E;
  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STK_DEPTH = 4;
  localparam logic [2:0] STK_FULL = 3'h4;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_MASK = 2'b01,
    KIND_NMI = 2'b10,
    KIND_TRAP = 2'b11
  } inc_kind_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_PSW = 2'b01,
    SQ_PC = 2'b10,
    SQ_VEC = 2'b11
  } inc_seq_t;

  typedef struct packed {
    logic done;
    logic trap;
    logic trap_ret;
    logic irq_ret;
    logic unmask_all;
    logic mask_all;
    logic psw_wr;
    logic psw_touch;
    logic irq_reg_touch;
    logic [7:0] psw_val;
  } inc_instr_t;

  typedef struct packed {
    logic save_psw;
    logic save_pc;
    logic load_vec;
    logic [7:0] program_state_word;
    logic [15:0] vec;
  } inc_save_t;

endpackage : inc_pkg

/* tb/inc_core_model.sv */
module inc_core_model
  import inc_pkg::*;
(
  input wire logic aclk,
  input wire inc_save_t save,
  output inc_instr_t instr
);
  timeunit 1ns;
  timeprecision 1ps;

  int gap = 0;

  initial instr = '0;

  // A taken acknowledge holds the next instruction back until the three
  // save pulses are over, as the real core is busy stacking meanwhile.
  task automatic exec(input inc_instr_t i, output logic acked);
    inc_instr_t v;
    v = i;
    v.done = 1'h1;
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    instr <= v;
    @(posedge aclk);
    instr <= '0;
    @(posedge aclk);
    acked = save.save_psw;
    if (acked)
      repeat (2) @(posedge aclk);
  endtask : exec
endmodule : inc_core_model

/* tb/tb_interrupt_nesting_and_test_inputs.sv */
module tb_interrupt_nesting_and_test_inputs
  import inc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NONE = 0;
  localparam int RTOUCH = 8;
  localparam int PTOUCH = 9;
  localparam int UNM = 12;
  localparam int IRET = 13;
  localparam int TRET = 14;
  localparam int TRAP = 15;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic nmi_req = 1'h0;
  logic wt = 1'h0;
  logic [7:0] src_req = 8'h00;
  logic [7:0] port4_in = 8'hFF;
  logic awready, wready, bvalid, arready, rvalid, standby, ak, s1, s2;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [15:0] last_vec;
  logic [7:0] last_psw, p, q;
  inc_instr_t instr;
  inc_save_t save;
  int bad_count = 0;
  int comparisons = 0;
  int acks = 0;
  int k, w;
  integer seed = 32'h50417e82;
  logic [7:0] ra [8] = '{OFF_REQ, OFF_MASK, OFF_PRIO, OFF_PSW, OFF_REQ1,
    OFF_MASK1, OFF_KRC, OFF_EDGE0};
  logic [7:0] rv [8] = '{RST_REQ, RST_MASK, RST_PRIO, RST_PSW, RST_REQ1,
    RST_MASK1, RST_KRC, RST_EDGE};

  initial forever #5 aclk = ~aclk;

  inc_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .instr(instr),
    .src_req(src_req), .nmi_req(nmi_req), .watch_overflow_test(wt),
    .port4_in(port4_in), .save(save), .standby_release(standby)
  );

  inc_core_model core (.aclk(aclk), .save(save), .instr(instr));

  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic expire(input int n);
    if (n >= 40)
    begin
      bad_count++;
      finish_test();
    end
  endtask : expire

  task automatic axi_wr(input logic [7:0] a, dt, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, dt};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      if (bvalid)
        break;
    end
    bready <= 1'h0;
    expire(n);
    check("bresp", bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
      if (rvalid)
        break;
    end
    d = rdata;
    rready <= 1'h0;
    expire(n);
  endtask : axi_rd

  task automatic pulses(input logic [7:0] s, input logic n, wv);
    @(posedge aclk);
    src_req <= s;
    nmi_req <= n;
    wt <= wv;
    @(posedge aclk);
    src_req <= 8'h00;
    nmi_req <= 1'h0;
    wt <= 1'h0;
  endtask : pulses

  task automatic run(input int bitpos, input logic [7:0] pv);
    logic [16:0] v;
    v = 17'h0;
    if (bitpos > 0)
      v[bitpos] = 1'h1;
    v[7:0] = pv;
    core.exec(inc_instr_t'(v), ak);
  endtask : run

  // Expected winner: lowest index of the high group, else of the low one.
  function automatic int pick(input logic [7:0] rq, pr);
    for (int i = 0; i < 8; i++)
      if (rq[i] && !pr[i])
        return i;
    for (int i = 0; i < 8; i++)
      if (rq[i])
        return i;
    return 0;
  endfunction : pick

  always @(posedge aclk)
  begin
    s1 <= save.save_psw;
    s2 <= s1;
    if (save.save_psw)
    begin
      acks++;
      last_vec = save.vec;
      last_psw = save.program_state_word;
    end
    if (s1)
      check("save_pc", save.save_pc, 32'h1);
    if (s2)
      check("load_vec", save.load_vec, 32'h1);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (k = 0; k < 8; k++)
    begin
      axi_rd(ra[k]);
      check("reset", d, {24'h0, rv[k]});
    end
    axi_rd(8'h80);
    check("rresp", rresp, RESP_SLVERR);
    axi_wr(8'h84, 8'h00, RESP_SLVERR);
    $display("reset test done");
    run(TRAP, 8'h00);
    check("ack", ak, 32'h1);
    check("vec", last_vec, VEC_TRAP);
    check("psw", last_psw, RST_PSW);
    run(TRET, 8'h02);
    axi_wr(OFF_MASK, 8'h00, RESP_OKAY);
    axi_wr(OFF_PRIO, 8'h00, RESP_OKAY);
    axi_wr(OFF_PSW, 8'h82, RESP_OKAY);
    pulses(8'h04, 1'h0, 1'h0);
    run(TRAP, 8'h00);
    check("psw", last_psw, 32'h82);
    axi_rd(OFF_PSW);
    check("psw ie", d, 32'h02);
    run(NONE, 8'h00);
    check("ack", ak, 32'h0);
    run(TRET, 8'h82);
    check("ack", ak, 32'h0);
    run(NONE, 8'h00);
    check("vec", last_vec, 32'h8);
    run(IRET, 8'h82);
    $display("trap test done");
    for (k = 0; k < 6; k++)
    begin
      p = $random(seed);
      q = $random(seed) | 8'h80;
      core.gap = $random(seed) & 3;
      w = pick(q, p);
      axi_wr(OFF_PRIO, p, RESP_OKAY);
      axi_wr(OFF_PSW, 8'h82, RESP_OKAY);
      pulses(q, 1'h0, 1'h0);
      run(NONE, 8'h00);
      check("vec", last_vec, VEC_MASK_BASE + 16'(2 * w));
      axi_rd(OFF_PSW);
      check("psw", d, p[w] ? 32'h02 : 32'h00);
      axi_rd(OFF_REQ);
      check("req", d, {24'h0, q & ~(8'h01 << w)});
      axi_wr(OFF_REQ, 8'h00, RESP_OKAY);
      run(IRET, 8'h82);
    end
    core.gap = 0;
    foreach (ra[j])
    begin
      if (j < 3)
      begin
        pulses(8'h01, 1'h0, 1'h0);
        run(j == 0 ? PTOUCH : j == 1 ? RTOUCH : UNM, 8'h82);
        check("deferred", ak, 32'h0);
        run(NONE, 8'h00);
        check("ack", ak, 32'h1);
        run(IRET, 8'h82);
      end
    end
    $display("priority test done");
    axi_wr(OFF_PRIO, 8'h00, RESP_OKAY);
    axi_wr(OFF_PSW, 8'h02, RESP_OKAY);
    pulses(8'h02, 1'h0, 1'h0);
    run(NONE, 8'h00);
    check("ack", ak, 32'h0);
    pulses(8'h00, 1'h1, 1'h0);
    run(NONE, 8'h00);
    check("vec", last_vec, VEC_NMI);
    axi_wr(OFF_PSW, 8'h80, RESP_OKAY);
    run(NONE, 8'h00);
    check("ack", ak, 32'h0);
    run(IRET, 8'h82);
    run(NONE, 8'h00);
    check("vec", last_vec, 32'h6);
    axi_wr(OFF_PSW, 8'h80, RESP_OKAY);
    pulses(8'h01, 1'h0, 1'h0);
    run(NONE, 8'h00);
    check("ack", ak, 32'h0);
    pulses(8'h00, 1'h1, 1'h0);
    run(NONE, 8'h00);
    check("vec", last_vec, VEC_NMI);
    axi_rd(OFF_STAT);
    check("stat", d, 32'h0A);
    $display("nesting test done");
    w = acks;
    pulses(8'h00, 1'h0, 1'h1);
    axi_rd(OFF_REQ1);
    check("watch", d, 32'h01);
    check("standby", standby, 32'h0);
    axi_wr(OFF_MASK1, 8'hFE, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("standby", standby, 32'h1);
    axi_rd(OFF_REQ1);
    check("held", d, 32'h01);
    axi_wr(OFF_REQ1, 8'h00, RESP_OKAY);
    axi_wr(OFF_KRC, 8'h00, RESP_OKAY);
    for (k = 0; k < 8; k++)
    begin
      @(posedge aclk);
      port4_in <= ~(8'h01 << k);
      @(posedge aclk);
      port4_in <= 8'hFF;
      axi_rd(OFF_REQ1);
      check("key", d, 32'h80);
      check("standby", standby, 32'h1);
      axi_wr(OFF_REQ1, 8'h00, RESP_OKAY);
    end
    repeat (2) @(posedge aclk);
    check("standby", standby, 32'h0);
    check("no vector", acks, w);
    $display("test input test done");
    finish_test();
  end
endmodule : tb_interrupt_nesting_and_test_inputs
